// file: include/wmc_pkg.sv
// Overview of operation
// - Command code 57h is decoded as the log write by DMA.
// - Log write by DMA checks and stores like the PIO log write 3Fh.
// - Abort a log write longer than the log's listed directory length.
// - Abort writes to read-only logs or logs of unsupported or disabled features.
// - Log address from sector number; start sector from cylinder-low current/previous.
// - Command code C5h is decoded as the multi-sector PIO write.
// - Accept sectors from the host, then commit each to the media.
// - Multi-sector write interrupts once per configured block, not per sector.
// - Sector data passes as 16-bit words.
// - Sector count zero means 256 sectors.
// - CHS mode: sector, cylinder high/low and head field give the start.
// - LBA mode: bits 0-23 from sector number, cylinder low, cylinder high.
// - LBA mode: bits 24-27 from the head field.
// - Sector count returns sectors not transferred, zero unless an error stopped it.
// - CHS mode: return address of the last transferred sector.
// - LBA mode: return last transferred LBA in the input layout.
package wmc_pkg;
    localparam logic [7:0] CMD_LOG_DMA_WR = 8'h57;
    localparam logic [7:0] CMD_LOG_PIO_WR = 8'h3F;
    localparam logic [7:0] CMD_MULT_WR    = 8'hC5;
    localparam int         DH_LBA_BIT     = 6;
    localparam int         DH_DRV_BIT     = 4;
    localparam int         ST_BUSY        = 7;
    localparam int         ST_READY       = 6;
    localparam int         ST_SEEK_DONE   = 4;
    localparam int         ST_DRQ         = 3;
    localparam int         ST_ERR         = 0;
    localparam int         ER_ID_NF       = 4;
    localparam int         ER_ABORT       = 2;
    localparam logic [7:0] WORD_LAST      = 8'hFF;
    localparam logic [8:0] CNT_ZERO_SECS  = 9'h100;
    localparam logic [7:0] SECS_PER_TRK   = 8'h3F;
    localparam logic [3:0] HEAD_LAST      = 4'hF;
    localparam logic [7:0] STATUS_RST     = 8'h50;
    localparam logic [7:0] ERROR_RST      = 8'h00;

    typedef struct packed {
        logic [7:0] cnt_prev;
        logic [7:0] cnt;
        logic [7:0] sec;
        logic [7:0] cyl_lo_prev;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] dev_head;
        logic [7:0] cmd;
    } wmc_tf_type;

    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] sec;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [3:0] head;
    } wmc_res_type;

    typedef enum logic [1:0] {
        WMC_IDLE   = 2'b00,
        WMC_XFER   = 2'b01,
        WMC_COMMIT = 2'b10
    } wmc_state_type;
endpackage

// file: verilog/wmc_write_cmd.sv
`timescale 1ns/1ns
`default_nettype none
module wmc_write_cmd
    import wmc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    // Task file command
    input  wire logic        i_cmd_wr,
    input  wire wmc_tf_type  i_tf,
    input  wire logic        i_dev_num,
    input  wire logic [7:0]  i_block_size,
    // Log directory facts for the addressed log
    input  wire logic [15:0] i_log_len,
    input  wire logic        i_log_read_only,
    input  wire logic        i_log_feature_ok,
    // Host data words
    input  wire logic        i_data_valid,
    input  wire logic [15:0] i_data,
    output logic             o_data_ready,
    output logic             o_dma_mode,
    // Media side
    output logic             o_media_valid,
    output logic [15:0]      o_media_data,
    output logic             o_commit,
    output logic [27:0]      o_commit_addr,
    input  wire logic        i_commit_done,
    input  wire logic        i_media_err,
    // Results
    output logic [7:0]       o_status,
    output logic [7:0]       o_error,
    output wmc_res_type      o_result,
    output logic             o_intrq
);
    wmc_state_type state;
    wmc_state_type next_state;
    logic [15:0]   rem;
    logic [7:0]    word_cnt;
    logic [7:0]    blk_cnt;
    logic [7:0]    cur_sec;
    logic [15:0]   cur_cyl;
    logic [3:0]    cur_head;
    logic [7:0]    last_sec;
    logic [15:0]   last_cyl;
    logic [3:0]    last_head;
    logic          lba_mode;
    logic          is_log;
    logic          err_flag;

    wire        dev_match   = i_tf.dev_head[DH_DRV_BIT] == i_dev_num;
    wire        tf_lba      = i_tf.dev_head[DH_LBA_BIT];
    wire        new_cmd     = i_cmd_wr && state == WMC_IDLE && dev_match;
    wire        is_c5       = i_tf.cmd == CMD_MULT_WR;
    wire        is_57       = i_tf.cmd == CMD_LOG_DMA_WR;
    wire [15:0] log_cnt     = {i_tf.cnt_prev, i_tf.cnt};
    wire        log_bad     = log_cnt == 16'h0000 || log_cnt > i_log_len
                              || i_log_read_only || !i_log_feature_ok;
    wire        c5_abort    = i_block_size == 8'h00;
    wire        c5_idnf     = !tf_lba && i_tf.sec == 8'h00;
    wire        start_c5    = new_cmd && is_c5 && !c5_abort && !c5_idnf;
    wire        start_57    = new_cmd && is_57 && !log_bad;
    wire        cmd_fail    = new_cmd && !start_c5 && !start_57;
    wire        fail_idnf   = is_c5 && !c5_abort && c5_idnf;
    wire        accept      = state == WMC_XFER && i_data_valid && o_data_ready;
    wire        sector_end  = accept && word_cnt == WORD_LAST;
    wire        commit_ok   = state == WMC_COMMIT && i_commit_done && !i_media_err;
    wire        commit_bad  = state == WMC_COMMIT && i_commit_done && i_media_err;
    wire        last_sector = rem == 16'h0001;
    wire        block_end   = !is_log && blk_cnt + 8'h01 == i_block_size;
    wire [27:0] lba_inc     = 28'({cur_head, cur_cyl, cur_sec}) + 28'h0000001;
    wire        sec_wrap    = cur_sec == SECS_PER_TRK;
    wire        head_wrap   = cur_head == HEAD_LAST;
    wire [7:0]  chs_sec     = sec_wrap ? 8'h01 : cur_sec + 8'h01;
    wire [3:0]  chs_head    = !sec_wrap ? cur_head : (head_wrap ? 4'h0 : cur_head + 4'h1);
    wire [15:0] chs_cyl     = (sec_wrap && head_wrap) ? cur_cyl + 16'h0001 : cur_cyl;
    wire [15:0] c5_cnt      = (i_tf.cnt == 8'h00) ? 16'(CNT_ZERO_SECS)
                              : {8'h00, i_tf.cnt};
    wire        next_ready  = (state == WMC_XFER && !sector_end) || start_c5 || start_57;
    wire        next_intrq  = commit_ok && (last_sector || block_end) || cmd_fail || commit_bad;
    wire [7:0]  next_status = {1'b0,
                               1'b1, 1'b0, 1'b1,
                               state == WMC_XFER && !is_log, 2'b00, err_flag};
    wire        busy_now    = state == WMC_COMMIT;

    always_comb begin
        next_state = state;
        case (state)
            WMC_IDLE: begin
                if (start_c5 || start_57) begin
                    next_state = WMC_XFER;
                end
            end
            WMC_XFER: begin
                if (sector_end) begin
                    next_state = WMC_COMMIT;
                end
            end
            WMC_COMMIT: begin
                if (commit_bad || (commit_ok && last_sector)) begin
                    next_state = WMC_IDLE;
                end else if (commit_ok) begin
                    next_state = WMC_XFER;
                end
            end
            default: begin
                next_state = WMC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= WMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rem      <= 16'h0000;
            blk_cnt  <= 8'h00;
            cur_sec  <= 8'h00;
            cur_cyl  <= 16'h0000;
            cur_head <= 4'h0;
            lba_mode <= 1'b0;
            is_log   <= 1'b0;
        end else if (start_c5) begin
            rem      <= c5_cnt;
            blk_cnt  <= 8'h00;
            cur_sec  <= i_tf.sec;
            cur_cyl  <= {i_tf.cyl_hi, i_tf.cyl_lo};
            cur_head <= i_tf.dev_head[3:0];
            lba_mode <= tf_lba;
            is_log   <= 1'b0;
        end else if (start_57) begin
            rem      <= log_cnt;
            blk_cnt  <= 8'h00;
            cur_sec  <= i_tf.sec;
            cur_cyl  <= {i_tf.cyl_lo_prev, i_tf.cyl_lo};
            cur_head <= 4'h0;
            lba_mode <= 1'b1;
            is_log   <= 1'b1;
        end else if (commit_ok) begin
            rem      <= rem - 16'h0001;
            blk_cnt  <= block_end ? 8'h00 : blk_cnt + 8'h01;
            if (is_log) begin
                cur_cyl <= cur_cyl + 16'h0001;
            end else if (lba_mode) begin
                {cur_head, cur_cyl, cur_sec} <= lba_inc;
            end else begin
                cur_sec  <= chs_sec;
                cur_head <= chs_head;
                cur_cyl  <= chs_cyl;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_sec  <= 8'h00;
            last_cyl  <= 16'h0000;
            last_head <= 4'h0;
        end else if (start_c5) begin
            last_sec  <= i_tf.sec;
            last_cyl  <= {i_tf.cyl_hi, i_tf.cyl_lo};
            last_head <= i_tf.dev_head[3:0];
        end else if (commit_ok) begin
            last_sec  <= cur_sec;
            last_cyl  <= cur_cyl;
            last_head <= cur_head;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            word_cnt <= 8'h00;
        end else if (start_c5 || start_57) begin
            word_cnt <= 8'h00;
        end else if (accept) begin
            word_cnt <= word_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_flag <= 1'b0;
            o_error  <= ERROR_RST;
        end else if (cmd_fail) begin
            err_flag <= 1'b1;
            o_error  <= {3'b000, fail_idnf, 1'b0, !fail_idnf, 2'b00};
        end else if (commit_bad) begin
            err_flag <= 1'b1;
            o_error  <= {3'b000, 1'b1, 4'b0000};
        end else if (new_cmd) begin
            err_flag <= 1'b0;
            o_error  <= ERROR_RST;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status      <= STATUS_RST;
            o_result      <= '0;
            o_data_ready  <= 1'b0;
            o_dma_mode    <= 1'b0;
            o_media_valid <= 1'b0;
            o_media_data  <= 16'h0000;
            o_commit      <= 1'b0;
            o_commit_addr <= 28'h0000000;
            o_intrq       <= 1'b0;
        end else begin
            o_status      <= {busy_now, next_status[6:0]};
            o_result      <= {rem[7:0], last_sec, last_cyl[7:0], last_cyl[15:8], last_head};
            o_data_ready  <= next_ready;
            o_dma_mode    <= start_57 || (is_log && state != WMC_IDLE && !commit_ok);
            o_media_valid <= accept;
            o_media_data  <= i_data;
            o_commit      <= sector_end;
            o_commit_addr <= {cur_head, cur_cyl, cur_sec};
            o_intrq       <= next_intrq;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    mult_start_a: assert property (start_c5 |=> state == WMC_XFER && !is_log)
        else $error("multi-sector write not started");
    log_start_a: assert property (start_57 |=> state == WMC_XFER && is_log ##1 o_dma_mode)
        else $error("log write by DMA not started");
    log_len_a: assert property (new_cmd && is_57 && log_cnt > i_log_len
                                |=> state == WMC_IDLE ##1 o_error[ER_ABORT] && o_status[ST_ERR])
        else $error("overlong log write not aborted");
    log_ro_a: assert property (new_cmd && is_57 && i_log_read_only |=> ##1 o_error[ER_ABORT])
        else $error("read-only log write not aborted");
    zero_cnt_a: assert property (start_c5 && i_tf.cnt == 8'h00 |=> rem == 16'h0100)
        else $error("zero count not taken as 256");
    word_pass_a: assert property (accept |=> o_media_valid && o_media_data == $past(i_data))
        else $error("data word not forwarded");
    commit_after_a: assert property (sector_end |=> o_commit ##1 state == WMC_COMMIT)
        else $error("sector not committed");
    block_irq_a: assert property (commit_ok && block_end && !last_sector |=> o_intrq)
        else $error("block interrupt missing");
    done_cnt_a: assert property (commit_ok && last_sector |=> ##1 o_result.cnt == 8'h00)
        else $error("remaining count not zero");
    err_status_a: assert property (commit_bad |=> ##1 o_status[ST_ERR] && !o_status[ST_BUSY]
                                   && o_error[ER_ID_NF])
        else $error("error status wrong");

    mult_done_c: cover property (commit_ok && last_sector && !is_log);
    log_done_c:  cover property (commit_ok && last_sector && is_log);
    media_err_c: cover property (commit_bad);
endmodule
`default_nettype wire

// file: tb/wmc_media_model.sv
`timescale 1ns/1ns
`default_nettype none
module wmc_media_model (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    // Commit handshake
    input  wire logic       i_restart,
    input  wire logic       i_commit,
    input  wire logic [3:0] i_delay,
    input  wire logic [8:0] i_fail_at,
    output logic            o_done,
    output logic            o_err
);
    logic [8:0] n;
    logic [3:0] wait_n;
    logic       pend;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            {n, wait_n, pend, o_done, o_err} <= '0;
        end else begin
            o_done <= 1'b0;
            // Error line toggles every cycle outside an answer
            o_err  <= ~o_err;
            if (i_restart) n <= 9'h000;
            if (i_commit) begin
                n      <= n + 9'h001;
                wait_n <= i_delay;
                pend   <= 1'b1;
            end else if (pend && wait_n != 4'h0) begin
                wait_n <= wait_n - 4'h1;
            end else if (pend) begin
                o_done <= 1'b1;
                o_err  <= (n == i_fail_at);
                pend   <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import wmc_pkg::*;
;
    logic        i_mclk, i_rst_b, cmd_wr, valid, dma, mvalid, ready, commit;
    logic        done, merr, intrq, ro, fok, saw_dma, dev;
    wmc_tf_type  tf;
    wmc_res_type res;
    logic [7:0]  blk, st, er, cprev, lprev;
    logic [15:0] len, mdata, wcnt, mcnt;
    logic [27:0] caddr, last_addr;
    logic [8:0]  fail_at;
    logic [3:0]  dly;
    int          err_count, cmp_count, cyc, irq_n;

    wmc_write_cmd i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cmd_wr(cmd_wr), .i_tf(tf),
        .i_dev_num(dev), .i_block_size(blk), .i_log_len(len), .i_log_read_only(ro),
        .i_log_feature_ok(fok), .i_data_valid(valid), .i_data(wcnt), .o_data_ready(ready),
        .o_dma_mode(dma), .o_media_valid(mvalid), .o_media_data(mdata), .o_commit(commit),
        .o_commit_addr(caddr), .i_commit_done(done), .i_media_err(merr), .o_status(st),
        .o_error(er), .o_result(res), .o_intrq(intrq));
    wmc_media_model i_media (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_restart(cmd_wr),
        .i_commit(commit), .i_delay(dly), .i_fail_at(fail_at), .o_done(done), .o_err(merr));

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end

    // Word source, forwarded-word checker and event recorders
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (valid && ready) wcnt <= wcnt + 16'h0001;
        if (mvalid === 1'b1) begin
            chk(mdata, mcnt);
            mcnt <= mcnt + 16'h0001;
        end
        if (commit === 1'b1) last_addr <= caddr;
        if (intrq === 1'b1) irq_n <= irq_n + 1;
        if (dma === 1'b1) saw_dma <= 1'b1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic run(input string name, input logic [7:0] cmd, cnt, sec, lo, hi, dh,
                       input logic [35:0] xres, input logic [7:0] xer, xst, input int xirq,
                       input logic [27:0] xaddr, input logic [15:0] xw);
        logic [15:0] w0;
        w0 = wcnt;
        irq_n = 0;
        saw_dma = 1'b0;
        tf = {cprev, cnt, sec, lprev, lo, hi, dh, cmd};
        cmd_wr = 1'b1;
        valid = 1'b1;
        @(posedge i_mclk);
        #1 cmd_wr = 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        // Wait until the command has ended: no busy, no data request, no ready and no DMA mode
        while (!(st[ST_BUSY] === 1'b0 && st[ST_DRQ] === 1'b0 && ready === 1'b0 && dma === 1'b0)) begin
            @(posedge i_mclk);
            #1;
        end
        repeat (2) @(posedge i_mclk);
        #1;
        if (cmd == CMD_MULT_WR && xer != 8'h04) chk(res, xres);
        chk(er, xer);
        chk(st, xst);
        chk(irq_n, xirq);
        chk(last_addr, xaddr);
        chk(saw_dma, cmd == CMD_LOG_DMA_WR && xer == 8'h00);
        chk(wcnt - w0, xw);
        $display("Test %s done", name);
    endtask

    task t_lba;
        blk = 8'h01;
        run("lba", CMD_MULT_WR, 8'h01, 8'h12, 8'h34, 8'h56, 8'h47, 36'h001234567, 8'h00, 8'h50, 1,
            28'h7563412, 16'h0100);
    endtask

    task t_chs;
        blk = 8'h02;
        dly = 4'h5;
        run("chs", CMD_MULT_WR, 8'h02, 8'h3E, 8'h01, 8'h00, 8'h02, 36'h003F01002, 8'h00, 8'h50, 1,
            28'h200013F, 16'h0200);
        dly = 4'h0;
    endtask

    task t_err;
        blk = 8'h04;
        fail_at = 9'h002;
        run("media_err", CMD_MULT_WR, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 36'hFF0000000, 8'h10, 8'h51, 1,
            28'h0000001, 16'h0200);
        fail_at = 9'h000;
    endtask

    task t_wrap;
        blk = 8'h01;
        dev = 1'b1;
        run("chs_wrap", CMD_MULT_WR, 8'h02, 8'h3F, 8'h01, 8'h00, 8'h1F, 36'h000102000, 8'h00, 8'h50, 2,
            28'h0000201, 16'h0200);
        run("chs_sector0", CMD_MULT_WR, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 36'h000102000, 8'h10, 8'h51, 1,
            28'h0000201, 16'h0000);
        dev = 1'b0;
    endtask

    task t_log;
        len = 16'h0001;
        lprev = 8'h01;
        run("log", CMD_LOG_DMA_WR, 8'h01, 8'hA0, 8'h05, 8'h00, 8'h00, 36'h0, 8'h00, 8'h50, 1,
            28'h00105A0, 16'h0100);
        run("log_len", CMD_LOG_DMA_WR, 8'h02, 8'hA0, 8'h05, 8'h00, 8'h00, 36'h0, 8'h04, 8'h51, 1,
            28'h00105A0, 16'h0000);
    endtask

    task t_abort;
        ro = 1'b1;
        run("log_ro", CMD_LOG_DMA_WR, 8'h01, 8'hA0, 8'h05, 8'h00, 8'h00, 36'h0, 8'h04, 8'h51, 1,
            28'h00105A0, 16'h0000);
        ro = 1'b0;
        fok = 1'b0;
        run("log_feat", CMD_LOG_DMA_WR, 8'h01, 8'hA0, 8'h05, 8'h00, 8'h00, 36'h0, 8'h04, 8'h51, 1,
            28'h00105A0, 16'h0000);
        blk = 8'h00;
        run("no_block", CMD_MULT_WR, 8'h01, 8'h01, 8'h00, 8'h00, 8'h40, 36'h0, 8'h04, 8'h51, 1,
            28'h00105A0, 16'h0000);
        blk = 8'h01;
        run("other_drive", CMD_MULT_WR, 8'h01, 8'h01, 8'h00, 8'h00, 8'h50, 36'h0, 8'h04, 8'h51, 0,
            28'h00105A0, 16'h0000);
    endtask

    initial begin
        {cmd_wr, valid, ro, saw_dma, dev, last_addr, blk, len, fail_at, dly, cprev, lprev} = '0;
        {wcnt, mcnt, cyc, irq_n, err_count, cmp_count} = '0;
        fok = 1'b1;
        tf = '0;
        i_rst_b = 1'b0;
        repeat (5) @(posedge i_mclk);
        #1 i_rst_b = 1'b1;
        chk(st, STATUS_RST);
        chk(er, ERROR_RST);
        t_lba();
        t_chs();
        t_err();
        t_wrap();
        t_log();
        t_abort();
        give_verdict();
    end
endmodule
`default_nettype wire
